// ==== rtl/slg_pkg.sv ====
package slg_pkg;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned SPIKE_MAX_US    = 10;   // Longest suppressed supply spike.
  localparam int unsigned RECOVER_MAX_US  = 100;  // Longest output recovery time.
  localparam int unsigned SPIKE_CYC       = SPIKE_MAX_US * (CLK_HZ / 1000000);
  localparam int unsigned RECOVER_CYC     = RECOVER_MAX_US * (CLK_HZ / 1000000);

  // ----------------------------------------------------------------------
  // Register map (word offsets as byte addresses).
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STAT   = 8'h04;
  localparam logic [7:0] REG_IRQ    = 8'h08;
  localparam logic [7:0] REG_MASK   = 8'h0C;
  localparam logic [7:0] REG_CMD    = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  localparam logic [7:0] REG_HELD   = 8'h18;

  // CTRL bits.
  localparam int unsigned CTRL_LOCK_REQ = 0;
  localparam int unsigned CTRL_POWER_UP = 1;

  // STAT bits.
  localparam int unsigned ST_LOCKED  = 0;
  localparam int unsigned ST_SUPV    = 1;
  localparam int unsigned ST_UV      = 2;
  localparam int unsigned ST_OV      = 3;
  localparam int unsigned ST_PEND    = 4;
  localparam int unsigned ST_READY   = 5;
  localparam int unsigned ST_HOLD    = 6;

  // IRQ bits.
  localparam int unsigned IRQ_W       = 5;
  localparam int unsigned IRQ_UV      = 0;
  localparam int unsigned IRQ_OV      = 1;
  localparam int unsigned IRQ_SPIKE   = 2;
  localparam int unsigned IRQ_REJECT  = 3;
  localparam int unsigned IRQ_RECOVER = 4;

  // Command field layout in REG_CMD: [31] is read, [15:0] data, [23:16] address.
  localparam int unsigned CMD_RD_BIT  = 31;
  localparam int unsigned CMD_LOCK_BIT = 30;

  typedef enum logic [1:0] {
    SLG_OFF,
    SLG_LOAD,
    SLG_RUN,
    SLG_RECOVER
  } slg_state_t;

  typedef struct packed {
    logic under_v;
    logic over_v;
    logic supply_ok;
  } slg_supply_t;

endpackage

// ==== rtl/slg_guard.sv ====
`timescale 1ns/1ps

// Summary of operation
// - Supply supervision only active when lock effective.
// - Spike up to 10 us keeps output value.
// - Output restored within 100 us after supply.
// - Lock request effective only after power cycle.
// - Locked device ignores program and read commands.
module slg_guard #(
  parameter int unsigned SPIKE_CYC   = slg_pkg::SPIKE_CYC,
  parameter int unsigned RECOVER_CYC = slg_pkg::RECOVER_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic               wb_we_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  output logic                    wb_ack_o,
  input  wire slg_pkg::slg_supply_t supply_i,
  input  wire logic               nvm_lock_i,
  input  wire logic               nvm_valid_i,
  input  wire logic [11:0]        field_output_value,
  output logic                    nvm_lock_wr_o,
  output logic [11:0]             out_value_o,
  output logic                    cmd_valid_o,
  output logic [31:0]             cmd_data_o,
  output logic                    irq_o
);

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  slg_pkg::slg_state_t state_q;
  logic        locked_q;
  logic        pend_q;
  logic        supv_q;
  logic        hold_q;
  logic [11:0] held_q;
  localparam int unsigned IRQ_LOCAL = slg_pkg::IRQ_W;
  logic [15:0] cnt_q;                // Consecutive low-supply cycles.
  logic [15:0] rcnt_q;               // Consecutive good-supply cycles while recovering.
  logic [15:0] rec_age_q;            // Recovery age kept apart for the checks.
  logic [IRQ_LOCAL-1:0] irq_stat_q;
  logic [IRQ_LOCAL-1:0] irq_mask_q;
  logic        ack_q;
  logic [31:0] rdat_q;

  // ----------------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------------
  wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr       = req & wb_we_i & wb_sel_i[0];
  wire rd       = req & ~wb_we_i;
  wire hit_ctrl = wb_adr_i == slg_pkg::REG_CTRL;
  wire hit_stat = wb_adr_i == slg_pkg::REG_STAT;
  wire hit_irq  = wb_adr_i == slg_pkg::REG_IRQ;
  wire hit_mask = wb_adr_i == slg_pkg::REG_MASK;
  wire hit_cmd  = wb_adr_i == slg_pkg::REG_CMD;
  wire hit_held = wb_adr_i == slg_pkg::REG_HELD;
  wire powered  = state_q != slg_pkg::SLG_OFF;
  wire running  = state_q == slg_pkg::SLG_RUN;
  // Commands are passed on only while running and unlocked.
  wire cmd_ok   = running & ~locked_q;
  wire cmd_wr   = wr & hit_cmd;
  wire reject   = cmd_wr & ~cmd_ok;
  wire lock_cmd = cmd_wr & cmd_ok & wb_dat_i[slg_pkg::CMD_LOCK_BIT];
  wire uv_ev    = supv_q & supply_i.under_v;
  wire ov_ev    = supv_q & supply_i.over_v;
  wire spike    = powered & ~supply_i.supply_ok;
  // A dropout longer than the spike limit is a real power-down; the lock then reloads.
  wire long_out = spike & (cnt_q >= 16'(SPIKE_CYC));
  wire rec_done = state_q == slg_pkg::SLG_RECOVER & supply_i.supply_ok &
                  (rcnt_q >= 16'(RECOVER_CYC - 1));
  wire [IRQ_LOCAL-1:0] irq_set = {rec_done, reject,
                                  spike & state_q == slg_pkg::SLG_RUN, ov_ev, uv_ev};
  wire [31:0] stat_word = {25'h0, hold_q, running, pend_q, supply_i.over_v & supv_q,
                           supply_i.under_v & supv_q, supv_q, locked_q};

  // ----------------------------------------------------------------------
  // Power state machine: off, load lock, run, recover after spike.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q  <= slg_pkg::SLG_OFF;
      locked_q <= 1'b0;
      supv_q   <= 1'b0;
      pend_q   <= 1'b0;
      cnt_q    <= 16'h0000;
      rcnt_q   <= 16'h0000;
    end else begin
      case (state_q)
        slg_pkg::SLG_OFF: begin
          cnt_q  <= 16'h0000;
          rcnt_q <= 16'h0000;
          if (wr & hit_ctrl & wb_dat_i[slg_pkg::CTRL_POWER_UP]) begin
            state_q <= slg_pkg::SLG_LOAD;
          end
        end
        slg_pkg::SLG_LOAD: begin
          // Lock is fetched before decoder and supervision open.
          if (nvm_valid_i) begin
            locked_q <= nvm_lock_i;
            supv_q   <= nvm_lock_i;
            pend_q   <= 1'b0;
            state_q  <= slg_pkg::SLG_RUN;
          end
        end
        slg_pkg::SLG_RUN: begin
          if (lock_cmd) begin
            pend_q <= 1'b1;
          end
          cnt_q  <= spike ? cnt_q + 16'h0001 : 16'h0000;
          rcnt_q <= 16'h0000;
          if (spike) begin
            state_q <= slg_pkg::SLG_RECOVER;
          end
        end
        slg_pkg::SLG_RECOVER: begin
          // Low cycles and good cycles are counted apart: a dropout that
          // returns before the limit restarts the recovery wait from zero,
          // so a bouncing supply cannot shorten it.
          cnt_q  <= supply_i.supply_ok ? 16'h0000 : cnt_q + 16'h0001;
          rcnt_q <= supply_i.supply_ok ? rcnt_q + 16'h0001 : 16'h0000;
          if (long_out) begin
            state_q <= slg_pkg::SLG_OFF;                               // Power lost.
            supv_q  <= 1'b0;
          end else if (rec_done) begin
            state_q <= slg_pkg::SLG_RUN;
            rcnt_q  <= 16'h0000;
          end
        end
        default: state_q <= slg_pkg::SLG_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Output hold: the last value is frozen across a short dropout.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      held_q      <= 12'h000;
      hold_q      <= 1'b0;
      out_value_o <= 12'h000;
    end else begin
      hold_q <= state_q == slg_pkg::SLG_RECOVER;
      if (running & ~spike) begin
        held_q      <= field_output_value;
        out_value_o <= field_output_value;
      end else begin
        out_value_o <= held_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave, one wait state; read of IRQ clears it.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q         <= 1'b0;
      rdat_q        <= 32'h0000_0000;
      irq_stat_q    <= '0;
      irq_mask_q    <= '0;
      cmd_valid_o   <= 1'b0;
      cmd_data_o    <= 32'h0000_0000;
      nvm_lock_wr_o <= 1'b0;
      irq_o         <= 1'b0;
    end else begin
      ack_q         <= req;
      cmd_valid_o   <= cmd_wr & cmd_ok;
      nvm_lock_wr_o <= lock_cmd;
      if (cmd_wr & cmd_ok) begin
        cmd_data_o <= wb_dat_i;
      end
      if (wr & hit_mask) begin
        irq_mask_q <= wb_dat_i[IRQ_LOCAL-1:0];
      end
      // Set wins over the clear-on-read.
      irq_stat_q <= ((rd & hit_irq) ? '0 : irq_stat_q) | irq_set;
      irq_o      <= |(irq_stat_q & irq_mask_q);
      rdat_q     <= hit_stat ? stat_word :
                    hit_irq  ? {27'h0, irq_stat_q} :
                    hit_mask ? {27'h0, irq_mask_q} :
                    hit_held ? {20'h0, held_q} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  a_supv_gated: assert property (@(posedge core_clk) disable iff (rst)
    supv_q |-> locked_q) else $error("Supervision active while unlocked.");
  a_lock_deferred: assert property (@(posedge core_clk) disable iff (rst)
    lock_cmd & ~locked_q |=> ~locked_q) else $error("Lock took effect early.");
  a_cmd_ignored: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr & locked_q |=> ~cmd_valid_o) else $error("Locked device took a command.");
  a_value_held: assert property (@(posedge core_clk) disable iff (rst)
    state_q == slg_pkg::SLG_RECOVER |=> out_value_o == $past(held_q)) else $error("Output lost.");
  a_recover_exit: assert property (@(posedge core_clk) disable iff (rst)
    rec_done |=> running) else $error("Recovery not finished.");
  a_load_first: assert property (@(posedge core_clk) disable iff (rst)
    state_q == slg_pkg::SLG_LOAD |-> ~cmd_ok & ~supv_q) else $error("Enabled before load.");

  // ----------------------------------------------------------------------
  // Check helpers.
  // ----------------------------------------------------------------------
  // Counts good-supply cycles spent recovering, apart from the state machine's
  // own counter, so that a stuck recovery counter cannot hide behind itself.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rec_age_q <= 16'h0000;
    end else if (state_q == slg_pkg::SLG_RECOVER & supply_i.supply_ok) begin
      rec_age_q <= rec_age_q + 16'h0001;
    end else begin
      rec_age_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Further checks.
  // ----------------------------------------------------------------------
  // Without the lock in force no under- or over-voltage event may reach the status bits.
  a_uv_gated: assert property (@(posedge core_clk) disable iff (rst)
    ~supv_q |-> ~irq_set[slg_pkg::IRQ_UV] & ~irq_set[slg_pkg::IRQ_OV])
    else $error("Supply event while unlocked.");
  // Once locked and running, the monitors must be on.
  a_supv_follows: assert property (@(posedge core_clk) disable iff (rst)
    running & locked_q |-> supv_q)
    else $error("Supervision off while locked.");
  // A dropout shorter than the limit must not power the block down.
  a_short_kept: assert property (@(posedge core_clk) disable iff (rst)
    state_q == slg_pkg::SLG_RECOVER & ~supply_i.supply_ok & (cnt_q < 16'(SPIKE_CYC))
    |=> powered)
    else $error("Short dropout lost power state.");
  // The hold flag follows the recovery state.
  a_hold_flag: assert property (@(posedge core_clk) disable iff (rst)
    state_q == slg_pkg::SLG_RECOVER |=> hold_q)
    else $error("Hold flag missing.");
  // The kept value must not move while the supply is in doubt.
  a_held_frozen: assert property (@(posedge core_clk) disable iff (rst)
    state_q == slg_pkg::SLG_RECOVER |=> $stable(held_q))
    else $error("Held value changed.");
  // A dropout seen while running is flagged.
  a_spike_flag: assert property (@(posedge core_clk) disable iff (rst)
    spike & running |=> irq_stat_q[slg_pkg::IRQ_SPIKE])
    else $error("Spike not flagged.");
  // Recovery never outlasts its bound of good-supply cycles.
  a_recover_bound: assert property (@(posedge core_clk) disable iff (rst)
    rec_age_q <= 16'(RECOVER_CYC))
    else $error("Recovery took too long.");
  // In normal running the output tracks the live value one cycle later.
  a_out_resumes: assert property (@(posedge core_clk) disable iff (rst)
    running & ~spike |=> out_value_o == $past(field_output_value))
    else $error("Output not tracking.");
  // While running, a pending lock never changes the lock state.
  a_run_locked: assert property (@(posedge core_clk) disable iff (rst)
    running & ~locked_q |=> ~locked_q)
    else $error("Lock changed while running.");
  // A long dropout is a power-down, after which the lock reloads.
  a_long_off: assert property (@(posedge core_clk) disable iff (rst)
    long_out |=> state_q == slg_pkg::SLG_OFF)
    else $error("Long dropout not a power-down.");
  // A refused command is always reported.
  a_reject_flag: assert property (@(posedge core_clk) disable iff (rst)
    reject |=> irq_stat_q[slg_pkg::IRQ_REJECT])
    else $error("Refused command not flagged.");
  // A passed command had the decoder open when it was taken.
  a_cmd_source: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid_o |-> $past(cmd_ok))
    else $error("Command passed while closed.");
  // A passed command carries the word that was written.
  a_cmd_data: assert property (@(posedge core_clk) disable iff (rst)
    cmd_valid_o |-> cmd_data_o == $past(wb_dat_i))
    else $error("Command word corrupted.");
  // Programming the lock bit needs an open decoder too.
  a_lock_wr_gated: assert property (@(posedge core_clk) disable iff (rst)
    nvm_lock_wr_o |-> $past(cmd_ok))
    else $error("Lock written while closed.");
  // Loading waits for the stored lock to be valid.
  a_load_wait: assert property (@(posedge core_clk) disable iff (rst)
    state_q == slg_pkg::SLG_LOAD & ~nvm_valid_i |=> state_q == slg_pkg::SLG_LOAD)
    else $error("Left load without lock.");
  // Powered down, nothing is open.
  a_off_quiet: assert property (@(posedge core_clk) disable iff (rst)
    state_q == slg_pkg::SLG_OFF |-> ~supv_q & ~cmd_ok)
    else $error("Open while powered down.");

endmodule

// ==== dv/slg_nvm_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Lock memory seen by the guard.
// ----------------------------------------------------------------------
module slg_nvm_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic lock_wr,
  output logic      lock_q,
  output logic      valid_q
);
  initial lock_q = 1'b0;

  // The stored bit survives reset because it models nonvolatile memory.
  always @(posedge core_clk) begin
    valid_q <= ~rst;
    if (lock_wr) begin
      lock_q <= 1'b1;
    end
  end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
  logic                 core_clk = 1'b0;
  logic                 rst      = 1'b1;
  logic [7:0]           wb_adr   = 8'h00;
  logic [31:0]          wb_wdat  = 32'h0;
  logic                 wb_we    = 1'b0;
  logic                 wb_cyc   = 1'b0;
  logic                 wb_stb   = 1'b0;
  logic [31:0]          wb_rdat;
  logic [31:0]          rd;
  logic                 wb_ack;
  logic                 nvm_lock;
  logic                 nvm_valid;
  logic                 lock_wr;
  logic                 cmd_valid;
  logic [31:0]          cmd_data;
  logic                 irq;
  slg_pkg::slg_supply_t sup      = 3'h1;
  logic [11:0]          field    = 12'h123;
  logic [11:0]          out_val;
  int                   err_count   = 0;
  int                   comparisons = 0;
  int                   cyc_n       = 0;
  int                   cmd_n       = 0;
  int                   n;

  always #20 core_clk = ~core_clk;

  slg_guard #(.SPIKE_CYC(8), .RECOVER_CYC(20)) i_dut (
    .core_clk(core_clk), .rst(rst), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_sel_i(4'hF), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .supply_i(sup), .nvm_lock_i(nvm_lock),
    .nvm_valid_i(nvm_valid), .field_output_value(field), .nvm_lock_wr_o(lock_wr),
    .out_value_o(out_val), .cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data), .irq_o(irq));

  slg_nvm_model i_nvm (.core_clk(core_clk), .rst(rst), .lock_wr(lock_wr),
    .lock_q(nvm_lock), .valid_q(nvm_valid));

  // Counts accepted commands and cuts a hung run short.
  always @(posedge core_clk) begin
    cyc_n++;
    if (cmd_valid === 1'b1) cmd_n++;
    if (cyc_n == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb_io(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    {wb_adr, wb_we, wb_wdat, wb_cyc, wb_stb} <= {a, w, d, 2'b11};
    do begin
      @(posedge core_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    {wb_we, wb_cyc, wb_stb} <= 3'b000;
  endtask

  task automatic wait_run();
    for (int k = 0; k < 60; k++) begin
      wb_io(slg_pkg::REG_STAT, 1'b0, 32'h0);
      if (rd[slg_pkg::ST_READY] === 1'b1) break;
    end
    chk("run_ready", 32'h1, {31'h0, rd[slg_pkg::ST_READY]});
  endtask

  // Programmer side of calibration: common settings, two field readings and
  // the computed pair, all before the lock request that follows.
  task automatic t_calib();
    int f1;
    int f2;
    int sens;
    int voq;
    n = cmd_n;
    for (int k = 0; k < 6; k++) begin
      wb_io(slg_pkg::REG_CMD, 1'b1, {8'h00, 8'(k), 16'h0011});
    end
    field <= 12'h100;
    repeat (3) @(posedge core_clk);
    wb_io(slg_pkg::REG_HELD, 1'b0, 32'h0);
    f1 = int'(rd);
    chk("field_pt1", 32'h100, rd);
    field <= 12'hF00;
    repeat (3) @(posedge core_clk);
    wb_io(slg_pkg::REG_HELD, 1'b0, 32'h0);
    f2 = int'(rd);
    chk("field_pt2", 32'hF00, rd);
    // Targets of 500 mV and 4500 mV on a 5000 mV supply, 4 V apart.
    sens = ((500 - 4500) * 65536) / ((f1 - f2) * 5000);
    voq = 500 - (f1 * sens * 5000) / 65536;
    wb_io(slg_pkg::REG_CMD, 1'b1, {8'h00, 8'h06, 16'(sens)});
    wb_io(slg_pkg::REG_CMD, 1'b1, {8'h00, 8'h07, 16'(voq)});
    chk("cmd_voq", {8'h00, 8'h07, 16'(voq)}, cmd_data);
    field <= 12'h123;
    repeat (3) @(posedge core_clk);
    chk("cmd_count", 32'd8, cmd_n - n);
  endtask

  // Low supply for c cycles; beyond eight the guard treats it as power-down.
  task automatic spike(input int c);
    @(posedge core_clk);
    sup.supply_ok <= 1'b0;
    repeat (c) @(posedge core_clk);
    sup.supply_ok <= 1'b1;
  endtask

  task automatic t_start();
    wb_io(slg_pkg::REG_CTRL, 1'b1, 32'h2);
    wait_run();
    sup.under_v <= 1'b1;
    wb_io(slg_pkg::REG_STAT, 1'b0, 32'h0);
    chk("stat_unlocked", 32'h20, rd & 32'h23);
    sup.under_v <= 1'b0;
    wb_io(slg_pkg::REG_IRQ, 1'b0, 32'h0);
    chk("irq_uv_unlocked", 32'h0, rd & 32'h3);
  endtask

  task automatic t_lock_req();
    wb_io(slg_pkg::REG_CMD, 1'b1, 32'h4000_0000);
    wb_io(slg_pkg::REG_STAT, 1'b0, 32'h0);
    chk("stat_pending", 32'h10, rd & 32'h11);
    n = cmd_n;
    wb_io(slg_pkg::REG_CMD, 1'b1, 32'h8000_0000);
    wb_io(slg_pkg::REG_CMD, 1'b1, 32'h0001_0055);
    repeat (3) @(posedge core_clk);
    chk("cmds_before_cycle", 32'd2, cmd_n - n);
  endtask

  task automatic t_spike();
    wb_io(slg_pkg::REG_MASK, 1'b1, 32'h14);
    chk("out_running", 32'h123, {20'h0, out_val});
    spike(5);
    field <= 12'h3A5;
    repeat (3) @(posedge core_clk);
    chk("out_held", 32'h123, {20'h0, out_val});
    repeat (26) @(posedge core_clk);
    chk("out_restored", 32'h3A5, {20'h0, out_val});
    chk("irq_level", 32'h1, {31'h0, irq});
    wb_io(slg_pkg::REG_IRQ, 1'b0, 32'h0);
    chk("irq_spike", 32'h14, rd & 32'h1F);
  endtask

  task automatic t_relock();
    spike(15);
    repeat (3) @(posedge core_clk);
    wb_io(slg_pkg::REG_CTRL, 1'b1, 32'h2);
    wait_run();
    chk("stat_locked", 32'h3, rd & 32'h3);
    wb_io(slg_pkg::REG_IRQ, 1'b0, 32'h0);
    n = cmd_n;
    wb_io(slg_pkg::REG_CMD, 1'b1, 32'h8000_0000);
    repeat (3) @(posedge core_clk);
    chk("cmd_ignored", n, cmd_n);
    sup.under_v <= 1'b1;
    repeat (3) @(posedge core_clk);
    sup.under_v <= 1'b0;
    wb_io(slg_pkg::REG_IRQ, 1'b0, 32'h0);
    chk("irq_reject_uv", 32'h9, rd & 32'h9);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_start();
    t_calib();
    t_lock_req();
    t_spike();
    t_relock();
    complete_run();
  end
endmodule
